/* common/rot_if.sv */
// Operand and result path between the sequencer and the rotate datapath
interface rot_if;
	rot_pkg::op_e op;
	logic [7:0] operand;
	logic carry_in;
	logic [7:0] flags_in;
	logic [7:0] result;
	logic [7:0] flags_out;

	modport dp(input op, operand, carry_in, flags_in, output result, flags_out);
	modport ctl(output op, operand, carry_in, flags_in, input result, flags_out);
endinterface : rot_if

/* common/rot_pkg.sv */
// Constants, types and timing tables shared by the rotate unit files
package rot_pkg;
	localparam int unsigned APB_AW = 8;

	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_run = 2'b01
	} st_e;

	typedef enum logic [1:0] {
		form_acc = 2'b00,
		form_reg = 2'b01,
		form_ptr = 2'b11,
		form_idx = 2'b10
	} form_e;

	typedef enum logic [2:0] {
		acc_rotate_left_circular = 3'h0,
		acc_rotate_left_through_carry = 3'h1,
		acc_rotate_right_circular = 3'h3,
		acc_rotate_right_through_carry = 3'h2,
		prefixed_rotate_left_circular = 3'h6
	} op_e;

	// Opcode bytes
	localparam logic [7:0] OPC_ACC_LEFT_CIRC = 8'h07;
	localparam logic [7:0] OPC_ACC_LEFT_CARRY = 8'h17;
	localparam logic [7:0] OPC_ACC_RIGHT_CIRC = 8'h0F;
	localparam logic [7:0] OPC_ACC_RIGHT_CARRY = 8'h1F;
	localparam logic [7:0] PREFIX_BITOP = 8'hCB;
	localparam logic [7:0] PREFIX_FIRST_INDEX = 8'hDD;
	localparam logic [7:0] PREFIX_SECOND_INDEX = 8'hFD;
	localparam logic [7:0] OPC_MEM_LEFT_CIRC = 8'h06;
	localparam logic [4:0] GROUP_LEFT_CIRC = 5'h00;
	localparam logic [2:0] SEL_MEM = 3'h6;

	// Register file byte slots, indexed by the operand field
	localparam logic [2:0] IDX_B = 3'h0;
	localparam logic [2:0] IDX_C = 3'h1;
	localparam logic [2:0] IDX_D = 3'h2;
	localparam logic [2:0] IDX_E = 3'h3;
	localparam logic [2:0] IDX_H = 3'h4;
	localparam logic [2:0] IDX_L = 3'h5;
	localparam logic [2:0] IDX_A = 3'h7;

	// Flag bit positions
	localparam int unsigned FLAG_SIGN = 7;
	localparam int unsigned FLAG_ZERO = 6;
	localparam int unsigned FLAG_HALF = 4;
	localparam int unsigned FLAG_PARITY = 2;
	localparam int unsigned FLAG_SUB = 1;
	localparam int unsigned FLAG_CARRY = 0;

	// Register offsets
	localparam logic [APB_AW-1:0] OFF_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] OFF_STATUS = 8'h04;
	localparam logic [APB_AW-1:0] OFF_INSTR = 8'h08;
	localparam logic [APB_AW-1:0] OFF_ACCF = 8'h0C;
	localparam logic [APB_AW-1:0] OFF_BC = 8'h10;
	localparam logic [APB_AW-1:0] OFF_DE = 8'h14;
	localparam logic [APB_AW-1:0] OFF_PTR = 8'h18;
	localparam logic [APB_AW-1:0] OFF_IDX1 = 8'h1C;
	localparam logic [APB_AW-1:0] OFF_IDX2 = 8'h20;

	localparam int unsigned CTRL_START = 0;
	localparam int unsigned STAT_BUSY = 0;
	localparam int unsigned STAT_ILLEGAL = 1;
	localparam int unsigned STAT_MCYC_LSB = 4;
	localparam int unsigned STAT_TST_LSB = 8;

	// Machine cycle lengths in T states, cycle 0 in the low slot
	localparam logic [2:0] T_OPFETCH = 3'h4;
	localparam logic [5:0][2:0] PTR_LEN = {3'h0, 3'h0, 3'h3, 3'h4, 3'h4, 3'h4};
	localparam logic [5:0][2:0] IDX_LEN = {3'h3, 3'h4, 3'h5, 3'h3, 3'h4, 3'h4};
	localparam logic [2:0] M_ACC = 3'h1;
	localparam logic [2:0] M_REG = 3'h2;
	localparam logic [2:0] M_PTR = 3'h4;
	localparam logic [2:0] M_IDX = 3'h6;
	localparam logic [4:0] T_ACC = 5'h04;
	localparam logic [4:0] T_REG = 5'h08;
	localparam logic [4:0] T_PTR = 5'h0F;
	localparam logic [4:0] T_IDX = 5'h17;
	localparam logic [2:0] PTR_RD = 3'h2;
	localparam logic [2:0] PTR_WR = 3'h3;
	localparam logic [2:0] IDX_CALC = 3'h3;
	localparam logic [2:0] IDX_RD = 3'h4;
	localparam logic [2:0] IDX_WR = 3'h5;

	function automatic logic [2:0] m_len(form_e f, logic [2:0] i);
		case (f)
			form_ptr: m_len = PTR_LEN[i];
			form_idx: m_len = IDX_LEN[i];
			default: m_len = T_OPFETCH;
		endcase
	endfunction : m_len

	function automatic logic [2:0] m_count(form_e f);
		case (f)
			form_reg: m_count = M_REG;
			form_ptr: m_count = M_PTR;
			form_idx: m_count = M_IDX;
			default: m_count = M_ACC;
		endcase
	endfunction : m_count
endpackage : rot_pkg

/* rtl/rotate_core.sv */
// Combinational rotate datapath with flag generation
module rotate_core (
	rot_if.dp rif // Operand in, result and flags out
);
	always_comb begin
		rif.flags_out = rif.flags_in;
		case (rif.op)
			rot_pkg::acc_rotate_left_circular: begin
				rif.result = {rif.operand[6:0], rif.operand[7]};
				rif.flags_out[rot_pkg::FLAG_CARRY] = rif.operand[7];
			end
			rot_pkg::acc_rotate_left_through_carry: begin
				rif.result = {rif.operand[6:0], rif.carry_in};
				rif.flags_out[rot_pkg::FLAG_CARRY] = rif.operand[7];
			end
			rot_pkg::acc_rotate_right_circular: begin
				rif.result = {rif.operand[0], rif.operand[7:1]};
				rif.flags_out[rot_pkg::FLAG_CARRY] = rif.operand[0];
			end
			rot_pkg::acc_rotate_right_through_carry: begin
				rif.result = {rif.carry_in, rif.operand[7:1]};
				rif.flags_out[rot_pkg::FLAG_CARRY] = rif.operand[0];
			end
			default: begin
				rif.result = {rif.operand[6:0], rif.operand[7]};
				rif.flags_out[rot_pkg::FLAG_CARRY] = rif.operand[7];
			end
		endcase
		// Accumulator forms keep sign, zero and parity
		rif.flags_out[rot_pkg::FLAG_HALF] = 1'b0;
		rif.flags_out[rot_pkg::FLAG_SUB] = 1'b0;
		if (rif.op == rot_pkg::prefixed_rotate_left_circular) begin
			rif.flags_out[rot_pkg::FLAG_SIGN] = rif.result[7];
			rif.flags_out[rot_pkg::FLAG_ZERO] = (rif.result == 8'h00);
			rif.flags_out[rot_pkg::FLAG_PARITY] = ~^rif.result;
		end
	end
endmodule : rotate_core

/* rtl/rotate_left_right_unit.sv */
// Rotate instruction unit: APB registers, decode, T-state sequencer, memory port
// Contract
// - Opcode 07h rotates the accumulator left with old bit 7 into carry and bit 0, in one 4-T machine cycle.
// - The four accumulator rotates clear half-carry and subtract and leave sign, zero and parity alone.
// - Opcode 17h rotates the accumulator left through carry in one 4-T machine cycle.
// - Opcode 0Fh rotates the accumulator right with old bit 0 into carry and bit 7, in one 4-T machine cycle.
// - Opcode 1Fh rotates the accumulator right through carry in one 4-T machine cycle.
// - Prefix CBh then 00000rrr selects a register by rrr, with 110 meaning memory.
// - The register form rotates the register left circularly in 2 machine cycles of 4 and 4 T.
// - Prefixed forms set sign, zero and even parity from the result, clear half-carry and subtract, carry from bit 7.
// - CBh 06h rotates the byte at the pointer pair in 4 machine cycles, 15 T as 4,4,4,3.
// - DDh CBh d 06h rotates the byte at first index plus d in 6 machine cycles, 23 T.
// - FDh CBh d 06h does the same with the second index register and the same timing.
// - The third byte is a signed displacement added to the 16-bit index to form the address.
module rotate_left_right_unit (
	input wire logic pclk, // Processor clock, one T state per rising edge
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB direction
	input wire logic [rot_pkg::APB_AW-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	output logic [15:0] mem_addr, // Operand memory address
	output logic mem_rd, // Operand read machine cycle
	output logic mem_wr, // Operand write machine cycle
	output logic [7:0] mem_wdata, // Write-back data
	input wire logic [7:0] mem_rdata, // Read data, synchronous to pclk
	output logic busy // Instruction in progress
);
	typedef struct packed {
		rot_pkg::st_e st;
		rot_pkg::form_e form;
		rot_pkg::op_e op;
		logic [2:0] sel;
		logic [2:0] mcyc;
		logic [2:0] tcnt;
		logic [4:0] tot;
		logic [31:0] instr;
		logic [7:0][7:0] gpr;
		logic [15:0] first_index_register;
		logic [15:0] second_index_register;
		logic [7:0] flags;
		logic [7:0] data;
		logic [15:0] addr;
		logic illegal;
		logic [2:0] last_m;
		logic [4:0] last_t;
		logic [31:0] prdata;
		logic pslverr;
	} state_s;

	state_s s;
	state_s next_s;
	rot_if rif();
	logic [7:0] b0;
	logic [7:0] b1;
	logic [7:0] b2;
	logic [7:0] b3;
	logic d_legal;
	rot_pkg::form_e d_form;
	rot_pkg::op_e d_op;
	logic [2:0] d_sel;
	logic is_mem;
	logic [2:0] rd_m;
	logic [2:0] wr_m;
	logic mend;
	logic fin;
	logic wr_acc;
	logic go;
	logic [31:0] rd_mux;
	logic mapped;
	logic [15:0] idx_addr;

	rotate_core u_core (
		.rif(rif.dp)
	);

	assign b0 = s.instr[7:0];
	assign b1 = s.instr[15:8];
	assign b2 = s.instr[23:16];
	assign b3 = s.instr[31:24];
	assign is_mem = (s.form == rot_pkg::form_ptr) || (s.form == rot_pkg::form_idx);
	assign rd_m = (s.form == rot_pkg::form_idx) ? rot_pkg::IDX_RD : rot_pkg::PTR_RD;
	assign wr_m = (s.form == rot_pkg::form_idx) ? rot_pkg::IDX_WR : rot_pkg::PTR_WR;
	assign mend = (s.st == rot_pkg::st_run) && (s.tcnt == rot_pkg::m_len(s.form, s.mcyc));
	assign fin = mend && (s.mcyc == rot_pkg::m_count(s.form) - 3'h1);
	assign wr_acc = psel && penable && pwrite;
	assign go = wr_acc && (paddr == rot_pkg::OFF_CTRL) && pwdata[rot_pkg::CTRL_START] && (s.st == rot_pkg::st_idle);
	// Signed displacement onto the selected index register
	assign idx_addr = ((b0 == rot_pkg::PREFIX_SECOND_INDEX) ? s.second_index_register : s.first_index_register)
		+ 16'($signed(b2));

	assign rif.op = s.op;
	assign rif.operand = is_mem ? mem_rdata : s.gpr[s.sel];
	assign rif.carry_in = s.flags[rot_pkg::FLAG_CARRY];
	assign rif.flags_in = s.flags;

	always_comb begin
		d_legal = 1'b1;
		d_form = rot_pkg::form_acc;
		d_op = rot_pkg::prefixed_rotate_left_circular;
		d_sel = rot_pkg::IDX_A;
		case (b0)
			rot_pkg::OPC_ACC_LEFT_CIRC: d_op = rot_pkg::acc_rotate_left_circular;
			rot_pkg::OPC_ACC_LEFT_CARRY: d_op = rot_pkg::acc_rotate_left_through_carry;
			rot_pkg::OPC_ACC_RIGHT_CIRC: d_op = rot_pkg::acc_rotate_right_circular;
			rot_pkg::OPC_ACC_RIGHT_CARRY: d_op = rot_pkg::acc_rotate_right_through_carry;
			rot_pkg::PREFIX_BITOP: begin
				d_sel = b1[2:0];
				d_legal = (b1[7:3] == rot_pkg::GROUP_LEFT_CIRC);
				d_form = (b1[2:0] == rot_pkg::SEL_MEM) ? rot_pkg::form_ptr : rot_pkg::form_reg;
			end
			rot_pkg::PREFIX_FIRST_INDEX, rot_pkg::PREFIX_SECOND_INDEX: begin
				d_form = rot_pkg::form_idx;
				// Final opcode byte sits after the displacement
				d_legal = (b1 == rot_pkg::PREFIX_BITOP) && (b3 == rot_pkg::OPC_MEM_LEFT_CIRC);
			end
			default: d_legal = 1'b0;
		endcase
	end

	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		case (paddr)
			rot_pkg::OFF_CTRL: rd_mux = 32'h0000_0000;
			rot_pkg::OFF_STATUS: begin
				rd_mux[rot_pkg::STAT_BUSY] = (s.st == rot_pkg::st_run);
				rd_mux[rot_pkg::STAT_ILLEGAL] = s.illegal;
				rd_mux[rot_pkg::STAT_MCYC_LSB +: 3] = s.last_m;
				rd_mux[rot_pkg::STAT_TST_LSB +: 5] = s.last_t;
			end
			rot_pkg::OFF_INSTR: rd_mux = s.instr;
			rot_pkg::OFF_ACCF: rd_mux[15:0] = {s.flags, s.gpr[rot_pkg::IDX_A]};
			rot_pkg::OFF_BC: rd_mux[15:0] = {s.gpr[rot_pkg::IDX_B], s.gpr[rot_pkg::IDX_C]};
			rot_pkg::OFF_DE: rd_mux[15:0] = {s.gpr[rot_pkg::IDX_D], s.gpr[rot_pkg::IDX_E]};
			rot_pkg::OFF_PTR: rd_mux[15:0] = {s.gpr[rot_pkg::IDX_H], s.gpr[rot_pkg::IDX_L]};
			rot_pkg::OFF_IDX1: rd_mux[15:0] = s.first_index_register;
			rot_pkg::OFF_IDX2: rd_mux[15:0] = s.second_index_register;
			default: mapped = 1'b0;
		endcase
	end

	always_comb begin
		next_s = s;
		// Answer prepared in the setup phase so read data leaves a flop
		if (psel && !penable) begin
			next_s.prdata = pwrite ? 32'h0000_0000 : rd_mux;
			next_s.pslverr = !mapped;
		end
		// Software may not disturb operands of a running instruction
		if (wr_acc && (s.st == rot_pkg::st_idle)) begin
			case (paddr)
				rot_pkg::OFF_INSTR: next_s.instr = pwdata;
				rot_pkg::OFF_ACCF: {next_s.flags, next_s.gpr[rot_pkg::IDX_A]} = pwdata[15:0];
				rot_pkg::OFF_BC: {next_s.gpr[rot_pkg::IDX_B], next_s.gpr[rot_pkg::IDX_C]} = pwdata[15:0];
				rot_pkg::OFF_DE: {next_s.gpr[rot_pkg::IDX_D], next_s.gpr[rot_pkg::IDX_E]} = pwdata[15:0];
				rot_pkg::OFF_PTR: {next_s.gpr[rot_pkg::IDX_H], next_s.gpr[rot_pkg::IDX_L]} = pwdata[15:0];
				rot_pkg::OFF_IDX1: next_s.first_index_register = pwdata[15:0];
				rot_pkg::OFF_IDX2: next_s.second_index_register = pwdata[15:0];
				default: next_s.instr = s.instr;
			endcase
		end
		case (s.st)
			rot_pkg::st_idle: begin
				if (go) begin
					next_s.illegal = !d_legal;
					next_s.form = d_form;
					next_s.op = d_op;
					next_s.sel = d_sel;
					next_s.addr = {s.gpr[rot_pkg::IDX_H], s.gpr[rot_pkg::IDX_L]};
					next_s.mcyc = 3'h0;
					next_s.tcnt = 3'h1;
					next_s.tot = 5'h01;
					if (d_legal) begin
						next_s.st = rot_pkg::st_run;
					end
				end
			end
			rot_pkg::st_run: begin
				next_s.tcnt = s.tcnt + 3'h1;
				next_s.tot = s.tot + 5'h01;
				if (mend) begin
					next_s.tcnt = 3'h1;
					next_s.mcyc = s.mcyc + 3'h1;
					if ((s.form == rot_pkg::form_idx) && (s.mcyc == rot_pkg::IDX_CALC)) begin
						next_s.addr = idx_addr;
					end
					// Memory forms latch the rotated byte and flags at read end
					if (is_mem && (s.mcyc == rd_m)) begin
						next_s.data = rif.result;
						next_s.flags = rif.flags_out;
					end
				end
				if (fin) begin
					next_s.st = rot_pkg::st_idle;
					next_s.last_m = s.mcyc + 3'h1;
					next_s.last_t = s.tot;
					if (!is_mem) begin
						next_s.gpr[s.sel] = rif.result;
						next_s.flags = rif.flags_out;
					end
				end
			end
			default: next_s.st = rot_pkg::st_idle;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pslverr = s.pslverr;
	assign pready = psel && penable;
	assign mem_addr = s.addr;
	assign mem_wdata = s.data;
	assign mem_rd = (s.st == rot_pkg::st_run) && is_mem && (s.mcyc == rd_m);
	assign mem_wr = (s.st == rot_pkg::st_run) && is_mem && (s.mcyc == wr_m);
	assign busy = (s.st == rot_pkg::st_run);

	// Helpers for the checks below
	logic [7:0] acc;
	logic [7:0] acc_q;
	logic [7:0] flags_q;
	logic [7:0] rd_q;
	logic [7:0] res_seen;
	logic flag_upd;
	assign acc = s.gpr[rot_pkg::IDX_A];
	assign res_seen = is_mem ? s.data : s.gpr[s.sel];
	assign flag_upd = (s.op == rot_pkg::prefixed_rotate_left_circular) && (is_mem ? (mend && s.mcyc == rd_m) : fin);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= 8'h00;
			flags_q <= 8'h00;
			rd_q <= 8'h00;
		end else begin
			acc_q <= acc;
			flags_q <= s.flags;
			rd_q <= mem_rd ? mem_rdata : rd_q;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence run_then_idle8;
		(s.st == rot_pkg::st_run) [*8] ##1 (s.st == rot_pkg::st_idle);
	endsequence
	sequence ptr_bus_walk;
		(!mem_rd && !mem_wr) [*8] ##1 mem_rd [*4] ##1 mem_wr [*3] ##1 (s.st == rot_pkg::st_idle);
	endsequence

	a_acc_left_circ: assert property (fin && s.op == rot_pkg::acc_rotate_left_circular |=>
		acc == {acc_q[6:0], acc_q[7]} && s.flags[rot_pkg::FLAG_CARRY] == acc_q[7] && s.last_t == rot_pkg::T_ACC)
		else $error("left circular accumulator rotate wrong");
	a_acc_flags_kept: assert property (fin && s.form == rot_pkg::form_acc |=>
		!s.flags[rot_pkg::FLAG_HALF] && !s.flags[rot_pkg::FLAG_SUB] && s.flags[7:6] == flags_q[7:6]
		&& s.flags[rot_pkg::FLAG_PARITY] == flags_q[rot_pkg::FLAG_PARITY])
		else $error("accumulator rotate flags wrong");
	a_acc_left_carry: assert property (fin && s.op == rot_pkg::acc_rotate_left_through_carry |=>
		acc == {acc_q[6:0], flags_q[rot_pkg::FLAG_CARRY]} && s.flags[rot_pkg::FLAG_CARRY] == acc_q[7])
		else $error("left through carry rotate wrong");
	a_acc_right_circ: assert property (fin && s.op == rot_pkg::acc_rotate_right_circular |=>
		acc == {acc_q[0], acc_q[7:1]} && s.flags[rot_pkg::FLAG_CARRY] == acc_q[0] && s.last_m == rot_pkg::M_ACC)
		else $error("right circular accumulator rotate wrong");
	a_acc_right_carry: assert property (fin && s.op == rot_pkg::acc_rotate_right_through_carry |=>
		acc == {flags_q[rot_pkg::FLAG_CARRY], acc_q[7:1]} && s.flags[rot_pkg::FLAG_CARRY] == acc_q[0])
		else $error("right through carry rotate wrong");
	a_reg_decode: assert property (go && b0 == rot_pkg::PREFIX_BITOP && b1[7:3] == rot_pkg::GROUP_LEFT_CIRC
		&& b1[2:0] != rot_pkg::SEL_MEM |=> s.form == rot_pkg::form_reg && s.sel == $past(b1[2:0]))
		else $error("register operand decode wrong");
	a_reg_timing: assert property (go && d_legal && d_form == rot_pkg::form_reg |=> run_then_idle8)
		else $error("register rotate not 8 T states");
	a_prefix_flags: assert property (flag_upd |=> s.flags[rot_pkg::FLAG_SIGN] == res_seen[7]
		&& s.flags[rot_pkg::FLAG_ZERO] == (res_seen == 8'h00) && s.flags[rot_pkg::FLAG_PARITY] == ~^res_seen
		&& !s.flags[rot_pkg::FLAG_HALF] && !s.flags[rot_pkg::FLAG_SUB] && s.flags[rot_pkg::FLAG_CARRY] == res_seen[0])
		else $error("prefixed rotate flags wrong");
	a_ptr_timing: assert property (go && d_legal && d_form == rot_pkg::form_ptr |=> ptr_bus_walk)
		else $error("pointer form machine cycles wrong");
	a_first_idx_time: assert property (go && d_legal && b0 == rot_pkg::PREFIX_FIRST_INDEX |=>
		##23 (s.st == rot_pkg::st_idle && s.last_t == rot_pkg::T_IDX && s.last_m == rot_pkg::M_IDX))
		else $error("first index form not 23 T states");
	a_second_idx_addr: assert property (go && d_legal && b0 == rot_pkg::PREFIX_SECOND_INDEX |=>
		##16 (mem_rd && $rose(mem_rd) && mem_addr == s.second_index_register + 16'($signed(b2)))
		##7 (s.last_t == rot_pkg::T_IDX))
		else $error("second index form address or timing wrong");
	a_first_idx_addr: assert property ($rose(mem_rd) && s.form == rot_pkg::form_idx
		&& b0 == rot_pkg::PREFIX_FIRST_INDEX |-> mem_addr == s.first_index_register + 16'($signed(b2)))
		else $error("displacement address wrong");
	a_mem_writeback: assert property ($rose(mem_wr) |->
		mem_wdata == {rd_q[6:0], rd_q[7]} && mem_addr == $past(mem_addr) && !mem_rd)
		else $error("write-back data or address wrong");
endmodule : rotate_left_right_unit

/* tb/tb_top.sv */
// Self-checking bench for the rotate unit: APB driver, memory responder, expected-value functions
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_rd, mem_wr, busy;
	logic [rot_pkg::APB_AW-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] mem_addr, rd_addr, wr_addr, seed;
	logic [7:0] mem_wdata, mem_val, wr_data;
	logic [7:0] mem_rdata = 8'h00;
	logic [7:0] n_rd = 8'h00;
	logic [7:0] n_wr = 8'h00;
	logic [7:0] ops[4] = '{8'h07, 8'h17, 8'h0F, 8'h1F};
	int n_fail = 0;
	int checks_done = 0;

	rotate_left_right_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .busy(busy));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	// Outside read cycles the data lines toggle so a stale byte is never mistaken for a good one
	always @(posedge pclk) begin
		mem_rdata <= (mem_rd === 1'b1) ? mem_val : ~mem_rdata;
		if (mem_rd === 1'b1) begin
			n_rd <= n_rd + 8'h01;
			rd_addr <= mem_addr;
		end
		if (mem_wr === 1'b1) begin
			n_wr <= n_wr + 8'h01;
			wr_addr <= mem_addr;
			wr_data <= mem_wdata;
		end
	end

	function automatic logic [7:0] rnd8();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed[7:0];
	endfunction : rnd8

	// Returns {flags, result}
	function automatic logic [15:0] exp_rot(input logic [7:0] opc, input logic [7:0] v, input logic [7:0] f);
		logic [7:0] r;
		case (opc)
			8'h17: r = {v[6:0], f[0]};
			8'h0F: r = {v[0], v[7:1]};
			8'h1F: r = {f[0], v[7:1]};
			default: r = {v[6:0], v[7]};
		endcase
		if (opc == 8'hCB)
			return {r[7], r == 8'h00, f[5], 1'b0, f[3], ~^r, 1'b0, v[7], r};
		return {(f & 8'hEC) | {7'h00, (opc[3] ? v[0] : v[7])}, r};
	endfunction : exp_rot

	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_data

	task automatic chk_cyc(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t cycles got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_cyc

	task automatic complete_run();
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	// One idle cycle between transfers keeps every strobe to one assignment per time step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic e;
		apb(1'b1, a, d, x, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic e;
		apb(1'b0, a, 32'h0, d, e);
	endtask : rd

	task automatic exec(input logic [31:0] ins, input logic [4:0] t, input logic [2:0] m);
		logic [31:0] s;
		logic [7:0] n;
		wr(rot_pkg::OFF_INSTR, ins);
		wr(rot_pkg::OFF_CTRL, 32'h1);
		n = 8'h00;
		#1;
		while (busy === 1'b1) begin
			n++;
			@(posedge pclk);
			#1;
		end
		chk_cyc(n, {3'h0, t});
		rd(rot_pkg::OFF_STATUS, s);
		chk_data(s & 32'h1F73, {19'h0, t, 1'b0, m, 4'h0});
	endtask : exec

	task automatic mem_case(input logic [31:0] ins, input logic [15:0] ea, input logic [4:0] t,
		input logic [2:0] m, input logic [7:0] v);
		logic [31:0] f0, f1;
		logic [15:0] e;
		logic [7:0] r0, w0;
		mem_val = v;
		rd(rot_pkg::OFF_ACCF, f0);
		e = exp_rot(8'hCB, v, f0[15:8]);
		r0 = n_rd;
		w0 = n_wr;
		exec(ins, t, m);
		rd(rot_pkg::OFF_ACCF, f1);
		chk_data({16'h0, rd_addr}, {16'h0, ea});
		chk_data({16'h0, wr_addr}, {16'h0, ea});
		chk_data({24'h0, wr_data}, {24'h0, e[7:0]});
		chk_data(f1 & 32'hD7FF, {16'h0, e[15:8] & 8'hD7, f0[7:0]});
		chk_cyc(n_rd - r0, 8'h04);
		chk_cyc(n_wr - w0, 8'h03);
	endtask : mem_case

	initial begin
		logic [31:0] w0, w1, f0, f1;
		logic [15:0] e, base, ea;
		logic [7:0] op, a, f, d, pre;
		logic err, hi;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0;
		mem_val = 8'h00;
		seed = 16'h287E;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(rot_pkg::OFF_STATUS, w0);
		chk_data(w0, 32'h0);
		for (int i = 0; i < 12; i++) begin
			op = ops[i % 4];
			a = (i < 4) ? 8'h80 : rnd8();
			f = (i < 4) ? 8'hFF : rnd8();
			wr(rot_pkg::OFF_ACCF, {16'h0, f, a});
			exec({24'h0, op}, rot_pkg::T_ACC, rot_pkg::M_ACC);
			rd(rot_pkg::OFF_ACCF, w1);
			e = exp_rot(op, a, f);
			chk_data(w1 & 32'hD7FF, {16'h0, e[15:8] & 8'hD7, e[7:0]});
		end
		$display("accumulator rotates done");
		for (int r = 0; r < 8; r++) begin
			if (r == 6)
				continue;
			wr(rot_pkg::OFF_BC, {16'h0, (r == 0) ? 16'h00A5 : {rnd8(), rnd8()}});
			wr(rot_pkg::OFF_DE, {16'h0, rnd8(), rnd8()});
			wr(rot_pkg::OFF_PTR, {16'h0, rnd8(), rnd8()});
			wr(rot_pkg::OFF_ACCF, {16'h0, rnd8(), rnd8()});
			a = (r == 7) ? rot_pkg::OFF_ACCF : (r < 2) ? rot_pkg::OFF_BC : (r < 4) ? rot_pkg::OFF_DE : rot_pkg::OFF_PTR;
			hi = (r != 7) && (r % 2 == 0);
			rd(a, w0);
			rd(rot_pkg::OFF_ACCF, f0);
			e = exp_rot(8'hCB, hi ? w0[15:8] : w0[7:0], f0[15:8]);
			exec({16'h0, 5'h00, 3'(r), 8'hCB}, rot_pkg::T_REG, rot_pkg::M_REG);
			rd(a, w1);
			rd(rot_pkg::OFF_ACCF, f1);
			w0 = hi ? {16'h0, e[7:0], w0[7:0]} : {16'h0, w0[15:8], e[7:0]};
			chk_data(w1 & ((r == 7) ? 32'hFF : 32'hFFFF), w0 & ((r == 7) ? 32'hFF : 32'hFFFF));
			chk_data(f1 & 32'hD700, {16'h0, e[15:8] & 8'hD7, 8'h00});
		end
		$display("register rotates done");
		base = {rnd8(), rnd8()};
		wr(rot_pkg::OFF_PTR, {16'h0, base});
		mem_case(32'h000006CB, base, rot_pkg::T_PTR, rot_pkg::M_PTR, 8'h00);
		mem_case(32'h000006CB, base, rot_pkg::T_PTR, rot_pkg::M_PTR, 8'h88);
		for (int i = 0; i < 6; i++) begin
			pre = (i % 2 == 0) ? 8'hDD : 8'hFD;
			base = (i == 0) ? 16'hFFF0 : (i == 1) ? 16'h0005 : {rnd8(), rnd8()};
			d = (i == 0) ? 8'h20 : (i == 1) ? 8'h80 : (i == 2) ? 8'h7F : rnd8();
			wr(rot_pkg::OFF_IDX1, {16'h0, (pre == 8'hDD) ? base : ~base});
			wr(rot_pkg::OFF_IDX2, {16'h0, (pre == 8'hFD) ? base : ~base});
			ea = base + {{8{d[7]}}, d};
			mem_case({8'h06, d, 8'hCB, pre}, ea, rot_pkg::T_IDX, rot_pkg::M_IDX, rnd8());
		end
		$display("memory rotates done");
		apb(1'b0, 8'h40, 32'h0, w0, err);
		chk_data({31'h0, err}, 32'h1);
		chk_data(w0, 32'h0);
		wr(rot_pkg::OFF_INSTR, 32'h000008CB);
		wr(rot_pkg::OFF_CTRL, 32'h1);
		#1;
		chk_cyc({7'h00, busy}, 8'h00);
		rd(rot_pkg::OFF_STATUS, w0);
		chk_data(w0 & 32'h3, 32'h2);
		$display("error cases done");
		complete_run();
	end

	initial begin
		repeat (30000) @(posedge pclk);
		n_fail++;
		complete_run();
	end
endmodule : tb_top
